// ### dv/psda_bridge_sva.sv
/*
 Port checker for the bridge: bus ack, core handshake, flash requests.
 Assumes it is bound to psda_bridge and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module psda_bridge_sva
	import psda_pkg::*;
(
	input wire logic            sys_clk,
	input wire logic            reset,
	input wire logic            wb_cyc_i,
	input wire logic            wb_stb_i,
	input wire logic            wb_ack_o,
	input wire logic            core_req_valid,
	input wire psda_core_req_t  core_req,
	input wire logic            core_req_ready,
	input wire logic            core_window_hit,
	input wire logic            core_rsp_valid,
	input wire logic            fl_req_valid,
	input wire psda_flash_req_t fl_req,
	input wire logic            fl_ack
);
	wire logic tk = core_req_valid && core_req_ready;
	wire logic trd = core_req.op == PSDA_OP_TRD_LO || core_req.op == PSDA_OP_TRD_HI;
	wire logic twr = core_req.op == PSDA_OP_TWR_LO || core_req.op == PSDA_OP_TWR_HI;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack late or long");
	a_hit_decode: assert property (
		core_window_hit |-> core_req.effective_address[WIN_EA_BIT] && !trd && !twr)
		else $error("window hit on wrong access");
	a_win_readonly: assert property (
		tk && core_window_hit && core_req.op == PSDA_OP_DATA_WR |=> !fl_req_valid[*2])
		else $error("window write reached flash");
	a_fl_hold: assert property (
		fl_req_valid && !fl_ack |=> fl_req_valid && $stable(fl_req))
		else $error("flash request moved");
	a_trd_addr: assert property (
		tk && trd |=> fl_req_valid && !fl_req.write && fl_req.config_space == fl_req.addr[23]
			&& fl_req.addr[15:1] == $past(core_req.effective_address[15:1]))
		else $error("table read address wrong");
	a_win_fetch: assert property (
		tk && core_window_hit && core_req.op == PSDA_OP_DATA_RD |=> fl_req_valid
			&& !fl_req.write && !fl_req.addr[23]
			&& fl_req.addr[14:1] == $past(core_req.effective_address[14:1]))
		else $error("window fetch address wrong");
	a_twr_path: assert property (
		tk && twr |=> (!fl_req_valid ##1 core_rsp_valid)
			or (fl_req_valid && fl_req.write && fl_req.config_space))
		else $error("table write path wrong");
	a_rsp_pulse: assert property (
		core_rsp_valid |=> !core_rsp_valid && core_req_ready)
		else $error("answer not a single pulse");
	a_busy_taken: assert property (
		tk |=> !core_req_ready until core_rsp_valid)
		else $error("ready while busy");
endmodule // psda_bridge_sva
bind psda_bridge psda_bridge_sva psda_bridge_sva_inst(.sys_clk, .reset, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .core_req_valid, .core_req, .core_req_ready, .core_window_hit,
	.core_rsp_valid, .fl_req_valid, .fl_req, .fl_ack);
`default_nettype wire

// ### dv/psda_bridge_test.sv
/*
 Self-checking bench for the bridge: registers, table and window paths.
 Assumes the flash model in psda_flash_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module psda_bridge_test
	import psda_pkg::*;
;
	logic sys_clk = 1'h0, reset = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h0, n_wr;
	logic [3:0] wb_sel_i = 4'h0, dly = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, core_req_valid = 1'h0, core_req_ready, core_window_hit;
	logic core_rsp_valid, fl_req_valid, fl_ack;
	psda_core_req_t core_req = '0;
	psda_flash_req_t fl_req;
	logic [15:0] core_rsp_data, lf = 16'h2d;
	logic [23:0] fl_rdata, prog_rd_data, row_base, last_wr;
	logic [ROW_IDX_W-1:0] prog_rd_idx = '0;
	int n_mismatch = 0, checks_done = 0;

	always #4 sys_clk = ~sys_clk;

	psda_bridge psda_bridge_inst(.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_req_valid, .core_req,
		.core_req_ready, .core_window_hit, .core_rsp_valid, .core_rsp_data, .fl_req_valid,
		.fl_req, .fl_ack, .fl_rdata, .prog_rd_idx, .prog_rd_data, .row_base);
	psda_flash_model psda_flash_model_inst(.sys_clk, .reset, .fl_req_valid, .fl_req, .dly,
		.fl_ack, .fl_rdata, .n_wr, .last_wr);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] fw(logic [23:0] a);
		a[0] = 1'h0;
		return a ^ {a[15:0], a[23:16]} ^ 24'h5a3c96;
	endfunction
	function automatic logic [15:0] nx(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [15:0] trd(psda_op_t op, logic bm, logic [23:0] a);
		logic [23:0] w;
		w = fw(a);
		if (op == PSDA_OP_TRD_LO)
			return bm ? {8'h0, a[0] ? w[15:8] : w[7:0]} : w[15:0];
		return (bm && a[0]) ? 16'h0 : {8'h0, w[23:16]};
	endfunction
	// Move, in repeat, edge iteration
	function automatic int pen(logic [2:0] m);
		return m[1] ? (m[0] ? 2 : 0) : (m[2] ? 1 : 2);
	endfunction

	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// A wait that runs out ends the run as a failure
	task lim(logic ok);
		if (!ok)
		begin
			n_mismatch++;
			conclude();
		end
	endtask
	task wb(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		for (int k = 0; k < 50; k++)
		begin
			@(posedge sys_clk);
			if (wb_ack_o === 1'h1)
				break;
		end
		lim(wb_ack_o === 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task core(psda_op_t op, logic bm, logic [15:0] ea, logic [15:0] wd, logic [2:0] m,
		output int n, output logic h, output logic [15:0] d);
		@(posedge sys_clk);
		core_req_valid <= 1'h1;
		core_req <= '{op, bm, ea, wd, m[2], m[1], m[0]};
		for (int k = 0; k < 50; k++)
		begin
			@(posedge sys_clk);
			if (core_req_ready === 1'h1)
				break;
		end
		lim(core_req_ready === 1'h1);
		h = core_window_hit;
		core_req_valid <= 1'h0;
		for (n = 1; n < 60; n++)
		begin
			@(negedge sys_clk);
			if (core_rsp_valid === 1'h1)
				break;
		end
		lim(core_rsp_valid === 1'h1);
		@(posedge sys_clk);
		d = core_rsp_data;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		n_mismatch++;
		conclude();
	end

	initial
	begin
		logic [31:0] q;
		int n, n0, w0;
		logic h, bm;
		logic [15:0] d, ea, mk;
		logic [23:0] e;
		logic [7:0] tp, wp;
		psda_op_t op;
		repeat (4) @(posedge sys_clk);
		reset <= 1'h0;
		for (int i = 0; i < 5; i++)
		begin
			wb(1'h0, 8'(4 * i), 32'h0, q);
			chk(q, 32'h0);
		end
		wb(1'h0, 8'h20, 32'h0, q);
		chk(q, 32'h0);
		wp = lf[15:8];
		wb(1'h1, REG_WINDOW_PAGE, {24'h0, wp}, q);
		wb(1'h0, REG_WINDOW_PAGE, 32'h0, q);
		chk(q, {24'h0, wp});
		$display("register test done");
		// Window on: table reads must ignore it
		wb(1'h1, REG_CORE_CONTROL, 32'h4, q);
		for (int i = 0; i < 24; i++)
		begin
			lf = nx(lf);
			tp = (i == 0) ? 8'hff : lf[7:0];
			lf = nx(lf);
			ea = (i == 0) ? 16'hffff : lf;
			dly <= {2'h0, lf[1:0]};
			op = lf[2] ? PSDA_OP_TRD_HI : PSDA_OP_TRD_LO;
			bm = lf[3];
			mk = bm ? 16'h00ff : 16'hffff;
			wb(1'h1, REG_TABLE_PAGE, {24'h0, tp}, q);
			core(op, bm, ea, 16'h0, 3'h0, n, h, d);
			chk(h, 1'h0);
			chk(d & mk, trd(op, bm, {tp, ea}) & mk);
		end
		$display("table read test done");
		dly <= 4'h0;
		core(PSDA_OP_DATA_RD, 1'h0, 16'h0122, 16'h0, 3'h0, n0, h, d);
		chk(h, 1'h0);
		for (int i = 0; i < 8; i++)
		begin
			lf = nx(lf);
			ea = {1'h1, lf[14:0]};
			core(PSDA_OP_DATA_RD, lf[15], ea, 16'h0, 3'(i), n, h, d);
			e = {1'h0, wp, ea[14:0]};
			chk(h, 1'h1);
			chk(d, trd(PSDA_OP_TRD_LO, lf[15], e));
			chk(n - n0, 2 + pen(3'(i)));
		end
		w0 = n_wr;
		core(PSDA_OP_DATA_WR, 1'h0, 16'hc000, 16'h1234, 3'h0, n, h, d);
		chk(h, 1'h1);
		chk(n_wr, w0);
		wb(1'h0, REG_STATUS, 32'h0, q);
		chk(q[STAT_REFUSED_BIT], 1'h1);
		wb(1'h1, REG_STATUS, 32'h2, q);
		wb(1'h0, REG_STATUS, 32'h0, q);
		chk(q[STAT_REFUSED_BIT], 1'h0);
		wb(1'h1, REG_CORE_CONTROL, 32'h0, q);
		core(PSDA_OP_DATA_RD, 1'h0, 16'h8000, 16'h0, 3'h0, n, h, d);
		chk(h, 1'h0);
		$display("window test done");
		tp = 8'h05;
		ea = 16'h0246;
		wb(1'h1, REG_TABLE_PAGE, {24'h0, tp}, q);
		core(PSDA_OP_TWR_LO, 1'h0, ea, 16'hbeef, 3'h0, n, h, d);
		core(PSDA_OP_TWR_HI, 1'h0, ea, 16'h00a5, 3'h0, n, h, d);
		// Odd byte of the low word, then the phantom byte: the latter touches nothing
		core(PSDA_OP_TWR_LO, 1'h1, ea + 16'h1, 16'h0077, 3'h0, n, h, d);
		core(PSDA_OP_TWR_HI, 1'h1, ea + 16'h1, 16'h0033, 3'h0, n, h, d);
		prog_rd_idx <= ea[6:1];
		repeat (2) @(posedge sys_clk);
		chk(prog_rd_data, 24'ha577ef);
		chk(row_base, {tp, ea} & 24'hffff80);
		chk(n_wr, w0);
		wb(1'h0, REG_STATUS, 32'h0, q);
		chk(q[STAT_ROW_LOAD_BIT], 1'h1);
		wb(1'h0, REG_ROW_BASE, 32'h0, q);
		chk(q, {8'h0, tp, ea & 16'hff80});
		wb(1'h1, REG_TABLE_PAGE, 32'h81, q);
		core(PSDA_OP_TWR_LO, 1'h0, 16'h0004, 16'h1111, 3'h0, n, h, d);
		chk(last_wr, 24'h810004);
		$display("table write test done");
		conclude();
	end
endmodule // psda_bridge_test
`default_nettype wire

// ### dv/psda_flash_model.sv
/*
 Behavioural program flash for the bridge bench: answers each request
 after a chosen delay, logs writes. Assumes one request at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module psda_flash_model
	import psda_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            reset,
	input  wire logic            fl_req_valid,
	input  wire psda_flash_req_t fl_req,
	input  wire logic [3:0]      dly,
	output logic                 fl_ack,
	output logic      [PW_W-1:0] fl_rdata,
	output logic      [7:0]      n_wr,
	output logic      [PW_W-1:0] last_wr
);
	logic [3:0]      cnt_r;
	logic [PW_W-1:0] junk_r;
	wire  [PW_W-1:0] a = {fl_req.addr[PW_W-1:1], 1'h0};
	assign fl_ack = fl_req_valid && cnt_r == dly;
	// Read data undefined outside ack: a moving pattern, never the last word
	assign fl_rdata = fl_ack ? a ^ {a[15:0], a[23:16]} ^ 24'h5a3c96 : junk_r;
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			cnt_r <= 4'h0;
			junk_r <= 24'h0;
			n_wr <= 8'h0;
			last_wr <= 24'h0;
		end
		else
		begin
			junk_r <= {junk_r[22:0], ~junk_r[23]};
			cnt_r <= (fl_ack || !fl_req_valid) ? 4'h0 : cnt_r + 4'h1;
			if (fl_ack && fl_req.write)
			begin
				n_wr <= n_wr + 8'h1;
				last_wr <= fl_req.addr;
			end
		end
	end
endmodule // psda_flash_model
`default_nettype wire

// ### rtl/psda_bridge.sv
/*
 Bridge between core data-space accesses and the program flash array:
 table reads and writes, the read-only visibility window, holding buffer.
 Assumes a Wishbone classic master for registers and a flash port that
 answers each request with a one-cycle ack.
*/
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
// What this block does
// - Table address is table page above the 16-bit effective address.
// - Table page top bit picks user (0) or configuration (1) memory.
// - Window address is window page above the low 15 effective address bits.
// - Window used only when address bit 15 and window enable are both set.
// - Window program address bit 15 comes from window page bit 0.
// - Words step by two; low word and upper byte share one range.
// - Read-low word mode returns program bits 15..0.
// - Read-low byte mode returns upper byte if byte select, else lower.
// - Read-high word mode returns bits 23..16, high data byte zero.
// - Read-high byte mode returns upper byte, or zero for phantom byte.
// - Write-low targets bits 15..0, write-high bits 23..16; byte and word.
// - Window covers data 8000h upward, onto any of 256 pages.
// - Window delivers only the low 16 bits of a program word.
// - Window is read-only; writes never reach program memory.
// - Window redirection suspended while a table access runs.
// - Window read takes an extra cycle for its second fetch.
// - Outside repeat: one extra cycle for moves, two for others.
// - In repeat: two extra on edge iterations, none on the others.
// - Rows of 64 words are programmed; erase pages hold 512 words.
// - Table writes to user flash only load holding buffers, two cycles.
`timescale 1ns/1ps
`default_nettype none
module psda_bridge
	import psda_pkg::*;
#(
	parameter int ROW_DEPTH = ROW_WORDS
) (
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [WB_AW-1:0]     wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [WB_DW-1:0]     wb_dat_i,
	output logic      [WB_DW-1:0]     wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 core_req_valid,
	input  wire psda_core_req_t       core_req,
	output logic                      core_req_ready,
	output logic                      core_window_hit,
	output logic                      core_rsp_valid,
	output logic      [15:0]          core_rsp_data,
	output logic                      fl_req_valid,
	output psda_flash_req_t           fl_req,
	input  wire logic                 fl_ack,
	input  wire logic [PW_W-1:0]      fl_rdata,
	input  wire logic [ROW_IDX_W-1:0] prog_rd_idx,
	output logic      [PW_W-1:0]      prog_rd_data,
	output logic      [PW_W-1:0]      row_base
);

	typedef enum logic [2:0] {
		S_IDLE    = 3'h0,
		S_FETCH   = 3'h1,
		S_PENALTY = 3'h2,
		S_BUFWR   = 3'h3,
		S_DONE    = 3'h4
	} psda_state_t;

	////////////////////////////////////////////////////////////////////////
	// Registers
	psda_state_t     state_r, state_nxt;
	psda_core_req_t  req_r;
	psda_flash_req_t fl_req_r, fl_req_nxt;
	logic [PG_W-1:0] table_page_r;
	logic [PG_W-1:0] window_page_r;
	logic [15:0]     core_control_r;
	logic            refused_r;
	logic            row_loaded_r;
	logic [PW_W-1:0] row_base_r;
	logic [PW_W-1:0] pdata_r;
	logic            win_r;
	logic            fetch_cnt_r;
	logic [1:0]      pen_cnt_r, pen_cnt_nxt;
	logic [15:0]     rsp_data_r;
	logic            ack_r;
	logic [WB_DW-1:0] dat_r;

	////////////////////////////////////////////////////////////////////////
	// Request decode
	wire is_tbl_in   = core_req.op inside {PSDA_OP_TRD_LO, PSDA_OP_TRD_HI,
		PSDA_OP_TWR_LO, PSDA_OP_TWR_HI};
	wire is_twr_in   = core_req.op inside {PSDA_OP_TWR_LO, PSDA_OP_TWR_HI};
	wire is_data_in  = !is_tbl_in;
	wire is_tbl_cur  = req_r.op inside {PSDA_OP_TRD_LO, PSDA_OP_TRD_HI,
		PSDA_OP_TWR_LO, PSDA_OP_TWR_HI};
	wire tbl_active  = (state_r != S_IDLE) && is_tbl_cur;
	wire win_en      = core_control_r[CTRL_WIN_EN_BIT];
	wire win_hit_in  = is_data_in && win_en && !tbl_active
		&& core_req.effective_address[WIN_EA_BIT];
	wire win_write   = win_hit_in && (core_req.op == PSDA_OP_DATA_WR);
	wire accept      = (state_r == S_IDLE) && core_req_valid;
	wire cfg_target  = table_page_r[CFG_PAGE_BIT];
	wire ea_bsel     = core_req.effective_address[0];

	wire [PW_W-1:0] tbl_addr = {table_page_r, core_req.effective_address};
	// Bit 15 of the address is dropped; the page supplies it and above
	wire [PW_W-1:0] win_addr = {1'b0, window_page_r,
		core_req.effective_address[WIN_LOW_BITS-1:0]};

	// Lane and data placement for table writes
	logic [2:0]      wr_lanes;
	logic [PW_W-1:0] wr_word;
	always_comb
	begin
		wr_lanes = 3'h0;
		wr_word  = '0;
		if (core_req.op == PSDA_OP_TWR_LO)
		begin
			wr_word  = {8'h00, core_req.byte_mode
				? {core_req.wdata[7:0], core_req.wdata[7:0]} : core_req.wdata};
			wr_lanes = !core_req.byte_mode ? 3'h3 : (ea_bsel ? 3'h2 : 3'h1);
		end
		else if (core_req.op == PSDA_OP_TWR_HI)
		begin
			wr_word  = {core_req.wdata[7:0], 16'h0000};
			// Phantom byte write has no storage behind it
			wr_lanes = (core_req.byte_mode && ea_bsel) ? 3'h0 : 3'h4;
		end
	end

	always_comb
	begin
		fl_req_nxt              = fl_req_r;
		fl_req_nxt.addr         = win_hit_in ? win_addr : tbl_addr;
		fl_req_nxt.config_space = !win_hit_in && cfg_target;
		fl_req_nxt.write        = is_twr_in;
		fl_req_nxt.wdata        = wr_word;
		fl_req_nxt.lanes        = wr_lanes;
	end

	// Window penalty after the second fetch
	always_comb
	begin
		if (req_r.in_repeat)
			pen_cnt_nxt = req_r.repeat_edge ? PEN_REPEAT_EDGE : PEN_REPEAT_MID;
		else
			pen_cnt_nxt = req_r.move_instr ? PEN_MOVE : PEN_OTHER;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:
			begin
				if (accept)
				begin
					if (win_write)
						state_nxt = S_DONE;
					else if (is_twr_in && !cfg_target)
						state_nxt = S_BUFWR;
					else if (is_tbl_in || (win_hit_in && core_req.op == PSDA_OP_DATA_RD))
						state_nxt = S_FETCH;
					else
						state_nxt = S_DONE;
				end
			end
			S_FETCH:
			begin
				if (fl_ack)
				begin
					if (win_r && (fetch_cnt_r != WIN_FETCHES_M1))
						state_nxt = S_FETCH;
					else if (win_r && (pen_cnt_nxt != 2'h0))
						state_nxt = S_PENALTY;
					else
						state_nxt = S_DONE;
				end
			end
			S_PENALTY:
				state_nxt = (pen_cnt_r == 2'h1) ? S_DONE : S_PENALTY;
			S_BUFWR:
				state_nxt = S_DONE;
			S_DONE:
				state_nxt = S_IDLE;
			default:
				state_nxt = S_IDLE;
		endcase
	end

	// Answer formatting
	wire [PW_W-1:0] rd_src = (state_r == S_FETCH) ? fl_rdata : pdata_r;
	wire            r_bsel = req_r.effective_address[0];
	logic [15:0]    fmt;
	always_comb
	begin
		fmt = 16'h0000;
		case (req_r.op)
			PSDA_OP_TRD_LO:
				fmt = !req_r.byte_mode ? rd_src[15:0]
					: {8'h00, r_bsel ? rd_src[15:8] : rd_src[7:0]};
			PSDA_OP_TRD_HI:
				fmt = (req_r.byte_mode && r_bsel) ? 16'h0000
					: {8'h00, rd_src[23:16]};
			PSDA_OP_DATA_RD:
				if (win_r)
					fmt = !req_r.byte_mode ? rd_src[15:0]
						: {8'h00, r_bsel ? rd_src[15:8] : rd_src[7:0]};
			default:
				fmt = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r     <= S_IDLE;
			req_r       <= '0;
			fl_req_r    <= '0;
			win_r       <= 1'b0;
			fetch_cnt_r <= 1'b0;
			pen_cnt_r   <= 2'h0;
			pdata_r     <= '0;
			rsp_data_r  <= 16'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			if (accept)
			begin
				req_r       <= core_req;
				fl_req_r    <= fl_req_nxt;
				win_r       <= win_hit_in;
				fetch_cnt_r <= 1'b0;
			end
			if (state_r == S_FETCH && fl_ack)
			begin
				pdata_r     <= fl_rdata;
				fetch_cnt_r <= 1'b1;
				pen_cnt_r   <= pen_cnt_nxt;
			end
			if (state_r == S_PENALTY)
				pen_cnt_r <= pen_cnt_r - 2'h1;
			if (state_nxt == S_DONE && state_r != S_DONE)
				rsp_data_r <= fmt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Holding buffer: one row, indexed by word within the row
	wire                 buf_wr  = accept && is_twr_in && !cfg_target && !win_hit_in;
	wire [ROW_IDX_W-1:0] buf_idx = core_req.effective_address[ROW_SPAN_W-1:1];

	psda_row_buf #(
		.DEPTH (ROW_DEPTH),
		.AW    (ROW_IDX_W),
		.LANES (3),
		.LW    (8)
	) u_row_buf (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.wr_en    (buf_wr),
		.wr_idx   (buf_idx),
		.wr_lanes (wr_lanes),
		.wr_data  (wr_word),
		.rd_idx   (prog_rd_idx),
		.rd_data  (prog_rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Register slave
	wire wb_req   = wb_cyc_i && wb_stb_i && !ack_r;
	wire wb_wr    = wb_req && wb_we_i;
	wire sel_tp   = wb_adr_i == REG_TABLE_PAGE;
	wire sel_wp   = wb_adr_i == REG_WINDOW_PAGE;
	wire sel_cc   = wb_adr_i == REG_CORE_CONTROL;
	wire sel_st   = wb_adr_i == REG_STATUS;
	wire sel_rb   = wb_adr_i == REG_ROW_BASE;
	wire clr_ref  = wb_wr && sel_st && wb_sel_i[0] && wb_dat_i[STAT_REFUSED_BIT];
	wire set_ref  = accept && win_write;
	wire busy     = state_r != S_IDLE;

	logic [WB_DW-1:0] rd_mux;
	always_comb
	begin
		rd_mux = '0;
		if (sel_tp)
			rd_mux[PG_W-1:0] = table_page_r;
		else if (sel_wp)
			rd_mux[PG_W-1:0] = window_page_r;
		else if (sel_cc)
			rd_mux[15:0] = core_control_r;
		else if (sel_st)
		begin
			rd_mux[STAT_BUSY_BIT]     = busy;
			rd_mux[STAT_REFUSED_BIT]  = refused_r;
			rd_mux[STAT_ROW_LOAD_BIT] = row_loaded_r;
		end
		else if (sel_rb)
			rd_mux[PW_W-1:0] = row_base_r;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			ack_r          <= 1'b0;
			dat_r          <= '0;
			table_page_r   <= PAGE_RESET;
			window_page_r  <= PAGE_RESET;
			core_control_r <= CTRL_RESET;
			refused_r      <= 1'b0;
			row_loaded_r   <= 1'b0;
			row_base_r     <= '0;
		end
		else
		begin
			ack_r <= wb_req;
			if (wb_req)
				dat_r <= rd_mux;
			if (wb_wr && sel_tp && wb_sel_i[0])
				table_page_r <= wb_dat_i[PG_W-1:0];
			if (wb_wr && sel_wp && wb_sel_i[0])
				window_page_r <= wb_dat_i[PG_W-1:0];
			if (wb_wr && sel_cc && wb_sel_i[0])
				core_control_r[7:0] <= wb_dat_i[7:0];
			if (wb_wr && sel_cc && wb_sel_i[1])
				core_control_r[15:8] <= wb_dat_i[15:8];
			// A refused write in the clearing cycle still shows
			if (set_ref)
				refused_r <= 1'b1;
			else if (clr_ref)
				refused_r <= 1'b0;
			if (buf_wr)
			begin
				row_loaded_r <= 1'b1;
				row_base_r   <= {tbl_addr[PW_W-1:ROW_SPAN_W], {ROW_SPAN_W{1'b0}}};
			end
			else if (wb_wr && sel_st && wb_sel_i[0] && wb_dat_i[STAT_ROW_LOAD_BIT])
				row_loaded_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_ack_o        = ack_r;
	assign wb_dat_o        = dat_r;
	assign core_req_ready  = state_r == S_IDLE;
	assign core_window_hit = win_hit_in;
	assign core_rsp_valid  = state_r == S_DONE;
	assign core_rsp_data   = rsp_data_r;
	assign fl_req_valid    = state_r == S_FETCH;
	assign fl_req          = fl_req_r;
	assign row_base        = row_base_r;

endmodule // psda_bridge
`default_nettype wire

// ### rtl/psda_pkg.sv
/*
 Shared constants and types for the program space data access bridge.
 Assumes a 16-bit core data path and a 24-bit program flash array.
*/
package psda_pkg;

	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int EA_W  = 16;
	localparam int PW_W  = 24;
	localparam int PG_W  = 8;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [WB_AW-1:0] REG_TABLE_PAGE   = 8'h00;
	localparam logic [WB_AW-1:0] REG_WINDOW_PAGE  = 8'h04;
	localparam logic [WB_AW-1:0] REG_CORE_CONTROL = 8'h08;
	localparam logic [WB_AW-1:0] REG_STATUS       = 8'h0c;
	localparam logic [WB_AW-1:0] REG_ROW_BASE     = 8'h10;

	localparam logic [PG_W-1:0] PAGE_RESET = 8'h00;
	localparam logic [15:0]     CTRL_RESET = 16'h0000;
	localparam int CTRL_WIN_EN_BIT   = 2;
	localparam int STAT_BUSY_BIT     = 0;
	localparam int STAT_REFUSED_BIT  = 1;
	localparam int STAT_ROW_LOAD_BIT = 2;

	////////////////////////////////////////////////////////////////////////
	// Address formation
	localparam int WIN_EA_BIT   = 15;
	localparam int CFG_PAGE_BIT = 7;
	localparam int WIN_LOW_BITS = 15;

	////////////////////////////////////////////////////////////////////////
	// Self-programming geometry
	localparam int ROW_WORDS   = 64;
	localparam int ROW_BYTES   = 192;
	localparam int ERASE_WORDS = 512;
	localparam int ERASE_BYTES = 1536;
	localparam int ROW_IDX_W   = $clog2(ROW_WORDS);
	localparam int ROW_SPAN_W  = ROW_IDX_W + 1;

	////////////////////////////////////////////////////////////////////////
	// Cycle figures
	localparam logic [1:0] PEN_MOVE        = 2'h1;
	localparam logic [1:0] PEN_OTHER       = 2'h2;
	localparam logic [1:0] PEN_REPEAT_EDGE = 2'h2;
	localparam logic [1:0] PEN_REPEAT_MID  = 2'h0;
	localparam logic       WIN_FETCHES_M1  = 1'b1;

	typedef enum logic [2:0] {
		PSDA_OP_DATA_RD = 3'h0,
		PSDA_OP_DATA_WR = 3'h1,
		PSDA_OP_TRD_LO  = 3'h2,
		PSDA_OP_TRD_HI  = 3'h3,
		PSDA_OP_TWR_LO  = 3'h4,
		PSDA_OP_TWR_HI  = 3'h5
	} psda_op_t;

	typedef struct packed {
		psda_op_t        op;
		logic            byte_mode;
		logic [EA_W-1:0] effective_address;
		logic [15:0]     wdata;
		logic            move_instr;
		logic            in_repeat;
		logic            repeat_edge;
	} psda_core_req_t;

	typedef struct packed {
		logic [PW_W-1:0] addr;
		logic            config_space;
		logic            write;
		logic [PW_W-1:0] wdata;
		logic [2:0]      lanes;
	} psda_flash_req_t;

endpackage

// ### rtl/psda_row_buf.sv
/*
 Programming holding buffer: one row of program words, per-byte-lane writes.
 Assumes a single clock; read data come out of a register.
*/
`timescale 1ns/1ps
`default_nettype none
module psda_row_buf #(
	parameter int DEPTH = 64,
	parameter int AW    = 6,
	parameter int LANES = 3,
	parameter int LW    = 8
) (
	input  wire logic                sys_clk,
	input  wire logic                reset,
	input  wire logic                wr_en,
	input  wire logic [AW-1:0]       wr_idx,
	input  wire logic [LANES-1:0]    wr_lanes,
	input  wire logic [LANES*LW-1:0] wr_data,
	input  wire logic [AW-1:0]       rd_idx,
	output logic      [LANES*LW-1:0] rd_data
);

	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			logic [LW-1:0] mem [DEPTH];

			always_ff @(posedge sys_clk)
			begin
				if (wr_en && wr_lanes[g])
					mem[wr_idx] <= wr_data[g*LW +: LW];
			end

			always_ff @(posedge sys_clk or posedge reset)
			begin
				if (reset)
					rd_data[g*LW +: LW] <= '0;
				else
					rd_data[g*LW +: LW] <= mem[rd_idx];
			end
		end
	endgenerate

endmodule // psda_row_buf
`default_nettype wire
